// File: core/fcs_byte.v
// one byte step of the ethernet frame check sequence
`timescale 1ns/10ps
`include "tail_tag_defines.vh"

module fcs_byte (
  input  wire [31:0] i_crc,
  input  wire [7:0]  i_data,
  output reg  [31:0] o_crc
);

  integer k;

  // ====================
  // reflected update, lsb first
  always @* begin
    o_crc = i_crc ^ {24'h000000, i_data};
    for (k = 0; k < 8; k = k + 1) begin
      o_crc = o_crc[0] ? ((o_crc >> 1) ^ `FCS_POLY) : (o_crc >> 1);
    end
  end

endmodule

// File: core/port_state_tail_tag.v
// port state control and host tail tag insert/strip
`timescale 1ns/10ps
`include "tail_tag_defines.vh"

// Behaviour
// - forwarding state forwards and learns normally
// - discarding blocks, no learning, override to host
// - flush port entries when learning disabled
// - learning state learns but blocks user traffic
// - eight trees, per-port state per tree
// - tag byte sits just before FCS
// - append ingress port tag toward host
// - tag bit 7 marks PTP timestamp present
// - bits 6:2 zero, bits 1:0 ingress port
// - strip host tag before frame leaves
// - lookup bit makes lower bits ignored
// - bits 4:0 ports/priority, bit 5 bypass
// - tagging only on the host port
// - bits 4:3 priority, bits 2:0 ports
module port_state_tail_tag (
  input  wire        i_ref_clk,
  input  wire        i_sys_rst,
  // apb slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr,
  // forwarding lookup gate
  input  wire        i_fw_valid,
  input  wire [2:0]  i_fw_tree,
  input  wire [1:0]  i_fw_src,
  input  wire [2:0]  i_fw_dst_mask,
  input  wire        i_fw_static_ovr,
  input  wire        i_fw_bypass,
  output wire        o_fw_valid,
  output wire [2:0]  o_fw_dst_mask,
  output wire        o_fw_learn,
  output wire [2:0]  o_flush_ports,
  output wire [2:0]  o_flush_tree,
  output wire        o_flush_req,
  // fabric to host port, frame without fcs
  input  wire        i_eh_valid,
  input  wire [7:0]  i_eh_data,
  input  wire        i_eh_last,
  input  wire [1:0]  i_eh_src_port,
  input  wire        i_eh_ptp,
  output wire        o_eh_ready,
  output wire        o_hx_valid,
  output wire [7:0]  o_hx_data,
  output wire        o_hx_last,
  input  wire        i_hx_ready,
  // host port to fabric, frame with tag and fcs
  input  wire        i_hr_valid,
  input  wire [7:0]  i_hr_data,
  input  wire        i_hr_last,
  output wire        o_hr_ready,
  output wire        o_hs_valid,
  output wire [7:0]  o_hs_data,
  output wire        o_hs_last,
  output wire        o_hs_lookup,
  output wire        o_hs_bypass,
  output wire [1:0]  o_hs_prio,
  output wire [2:0]  o_hs_ports,
  input  wire        i_hs_ready,
  output wire [1:0]  o_host_port,
  output wire        o_tag_on
);

  localparam E_DATA = 2'h0;
  localparam E_TAG  = 2'h1;
  localparam E_FCS  = 2'h2;
  localparam I_DATA = 1'b0;
  localparam I_FCS  = 1'b1;

  reg  [31:0] ctrl_r;
  reg  [23:0] st_r [0:2];
  reg  [15:0] tag_cnt_r;
  reg  [15:0] strip_cnt_r;
  reg  [7:0]  last_tag_r;
  reg  [31:0] rdata;
  reg         hit;
  reg  [2:0]  flush_ports_r;
  reg  [2:0]  flush_tree_r;
  reg         flush_req_r;
  reg         fw_valid_r;
  reg  [2:0]  fw_mask_r;
  reg         fw_learn_r;
  wire [71:0] st_flat;
  wire [2:0]  gate_mask;
  wire        gate_learn;
  wire [2:0]  tag_en;
  wire        tag_on;
  wire [1:0]  host;
  wire        wr;
  wire [2:0]  fl_ports;
  wire [2:0]  fl_tree;
  wire [2:0]  fl_ok;

  // ====================
  // apb slave, zero wait states
  assign wr        = i_psel & i_penable & i_pwrite;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~hit;
  assign o_prdata  = (i_psel & i_penable & ~i_pwrite) ? rdata : 32'h0;

  // read mux and address decode
  always @* begin
    hit   = 1'b1;
    rdata = 32'h0;
    case (i_paddr)
      `REG_CTRL:     rdata = ctrl_r;
      `REG_STATE_P1: rdata = {8'h00, st_r[0]};
      `REG_STATE_P2: rdata = {8'h00, st_r[1]};
      `REG_STATE_P3: rdata = {8'h00, st_r[2]};
      `REG_FLUSH:    rdata = 32'h0;
      `REG_STATUS:   rdata = {strip_cnt_r, tag_cnt_r};
      `REG_LAST_TAG: rdata = {24'h000000, last_tag_r};
      default:       hit   = 1'b0;
    endcase
  end

  // control register, tagging off after reset
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ctrl_r <= `CTRL_RESET;
    end else if (wr && i_paddr == `REG_CTRL) begin
      ctrl_r <= {23'h000000, i_pwdata[`CTRL_PTP_EN_BIT], 5'h00,
                 i_pwdata[`CTRL_TAG_EN_MSB:`CTRL_TAG_EN_LSB]};
    end
  end

  // per-port, per-tree state registers
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_st
      always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
          st_r[g] <= `ST_RESET;
        end else if (wr && i_paddr == (`REG_STATE_P1 + 8'h04 * g)) begin
          st_r[g] <= i_pwdata[23:0];
        end
      end
      assign st_flat[g*`ST_REG_W +: `ST_REG_W] = st_r[g];
      assign fl_ok[g] = fl_ports[g] & st_r[g][fl_tree*`ST_FIELD_W + `ST_LRN_DIS_BIT];
    end
  endgenerate

  // ====================
  // host port selection, lowest enabled port wins if misprogrammed
  assign tag_en      = ctrl_r[`CTRL_TAG_EN_MSB:`CTRL_TAG_EN_LSB];
  assign tag_on      = |tag_en;
  assign host        = tag_en[0] ? 2'h0 : (tag_en[1] ? 2'h1 : 2'h2);
  assign o_host_port = host;
  assign o_tag_on    = tag_on;

  // flush only ports with learning disabled in that tree
  assign fl_ports = i_pwdata[`FLUSH_PORT_MSB:`FLUSH_PORT_LSB];
  assign fl_tree  = i_pwdata[`FLUSH_TREE_MSB:`FLUSH_TREE_LSB];
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      flush_req_r   <= 1'b0;
      flush_ports_r <= 3'h0;
      flush_tree_r  <= 3'h0;
    end else begin
      flush_req_r <= wr && i_paddr == `REG_FLUSH && (|fl_ok);
      if (wr && i_paddr == `REG_FLUSH) begin
        flush_ports_r <= fl_ok;
        flush_tree_r  <= fl_tree;
      end
    end
  end
  assign o_flush_req   = flush_req_r;
  assign o_flush_ports = flush_ports_r;
  assign o_flush_tree  = flush_tree_r;

  // ====================
  // forwarding gate, one cycle latency
  tree_gate u_gate (
    .i_states     (st_flat),
    .i_tree       (i_fw_tree),
    .i_src        (i_fw_src),
    .i_dst_mask   (i_fw_dst_mask),
    .i_host       (host),
    .i_tag_on     (tag_on),
    .i_static_ovr (i_fw_static_ovr),
    .i_bypass     (i_fw_bypass),
    .o_dst_mask   (gate_mask),
    .o_learn      (gate_learn)
  );

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      fw_valid_r <= 1'b0;
      fw_mask_r  <= 3'h0;
      fw_learn_r <= 1'b0;
    end else begin
      fw_valid_r <= i_fw_valid;
      fw_mask_r  <= i_fw_valid ? gate_mask : 3'h0;
      fw_learn_r <= i_fw_valid & gate_learn;
    end
  end
  assign o_fw_valid    = fw_valid_r;
  assign o_fw_dst_mask = fw_mask_r;
  assign o_fw_learn    = fw_learn_r;

  // ====================
  // toward host: data, then tag, then fresh fcs
  reg  [1:0]  e_st_r;
  reg  [1:0]  e_fc_r;
  reg  [7:0]  e_tag_r;
  reg  [31:0] e_crc_r;
  reg         hx_valid_r;
  reg  [7:0]  hx_data_r;
  reg         hx_last_r;
  reg         e_have;
  reg  [7:0]  e_byte;
  wire        e_adv;
  wire        e_load;
  wire [31:0] e_crc_nxt;
  wire [31:0] e_fcs;

  assign e_adv      = ~hx_valid_r | i_hx_ready;
  assign o_eh_ready = e_adv & (e_st_r == E_DATA);
  assign e_load     = e_adv & e_have;
  assign e_fcs      = ~e_crc_r;

  // next byte toward the host
  always @* begin
    e_have = 1'b0;
    e_byte = 8'h00;
    case (e_st_r)
      E_DATA: begin
        e_have = i_eh_valid;
        e_byte = i_eh_data;
      end
      E_TAG: begin
        e_have = 1'b1;
        e_byte = e_tag_r;
      end
      E_FCS: begin
        e_have = 1'b1;
        e_byte = e_fcs[e_fc_r*8 +: 8];
      end
      default: begin
        e_have = 1'b0;
      end
    endcase
  end

  fcs_byte u_efcs (
    .i_crc  (e_crc_r),
    .i_data (e_byte),
    .o_crc  (e_crc_nxt)
  );

  // egress sequencing and output register
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      e_st_r     <= E_DATA;
      e_fc_r     <= 2'h0;
      e_tag_r    <= 8'h00;
      e_crc_r    <= `FCS_INIT;
      hx_valid_r <= 1'b0;
      hx_data_r  <= 8'h00;
      hx_last_r  <= 1'b0;
      tag_cnt_r  <= 16'h0000;
    end else begin
      if (e_adv) begin
        hx_valid_r <= e_have;
        hx_data_r  <= e_byte;
        hx_last_r  <= (e_st_r == E_FCS) && (e_fc_r == 2'h3);
      end
      if (e_load && e_st_r != E_FCS) begin
        e_crc_r <= e_crc_nxt;
      end
      case (e_st_r)
        E_DATA: begin
          if (e_load && i_eh_last) begin
            // ptp flag, reserved zeros, ingress port code
            e_tag_r <= {ctrl_r[`CTRL_PTP_EN_BIT] & i_eh_ptp, 5'h00,
                        i_eh_src_port};
            e_st_r  <= tag_on ? E_TAG : E_FCS;
          end
        end
        E_TAG: begin
          if (e_load) begin
            e_st_r    <= E_FCS;
            tag_cnt_r <= tag_cnt_r + 16'h0001;
          end
        end
        E_FCS: begin
          if (e_load) begin
            e_fc_r <= e_fc_r + 2'h1;
            if (e_fc_r == 2'h3) begin
              e_st_r  <= E_DATA;
              e_crc_r <= `FCS_INIT;
            end
          end
        end
        default: e_st_r <= E_DATA;
      endcase
    end
  end
  assign o_hx_valid = hx_valid_r;
  assign o_hx_data  = hx_data_r;
  assign o_hx_last  = hx_last_r;

  // ====================
  // from host: hold five bytes back, drop tag and old fcs, add new fcs
  reg         i_st_r;
  reg  [1:0]  i_fc_r;
  reg  [39:0] sr_r;
  reg  [2:0]  sr_cnt_r;
  reg  [31:0] i_crc_r;
  reg         hs_valid_r;
  reg  [7:0]  hs_data_r;
  reg         hs_last_r;
  reg  [7:0]  itag_r;
  reg         i_have;
  reg  [7:0]  i_byte;
  wire        i_adv;
  wire        i_take;
  wire        sr_full;
  wire [31:0] i_crc_nxt;
  wire [31:0] i_fcs;

  assign i_adv      = ~hs_valid_r | i_hs_ready;
  assign o_hr_ready = i_adv & (i_st_r == I_DATA);
  assign i_take     = i_hr_valid & o_hr_ready;
  assign sr_full    = (sr_cnt_r == `STRIP_DEPTH);
  assign i_fcs      = ~i_crc_r;

  // next byte toward the fabric
  always @* begin
    i_have = 1'b0;
    i_byte = 8'h00;
    if (i_st_r == I_FCS) begin
      i_have = 1'b1;
      i_byte = i_fcs[i_fc_r*8 +: 8];
    end else if (!tag_on) begin
      i_have = i_hr_valid;
      i_byte = i_hr_data;
    end else begin
      i_have = i_hr_valid & sr_full;
      i_byte = sr_r[39:32];
    end
  end

  fcs_byte u_ifcs (
    .i_crc  (i_crc_r),
    .i_data (i_byte),
    .o_crc  (i_crc_nxt)
  );

  // strip sequencing and output register
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      i_st_r      <= I_DATA;
      i_fc_r      <= 2'h0;
      sr_r        <= 40'h0;
      sr_cnt_r    <= 3'h0;
      i_crc_r     <= `FCS_INIT;
      hs_valid_r  <= 1'b0;
      hs_data_r   <= 8'h00;
      hs_last_r   <= 1'b0;
      itag_r      <= 8'h00;
      last_tag_r  <= 8'h00;
      strip_cnt_r <= 16'h0000;
    end else begin
      if (i_adv) begin
        hs_valid_r <= i_have;
        hs_data_r  <= i_byte;
        hs_last_r  <= (i_st_r == I_FCS) ? (i_fc_r == 2'h3) : (!tag_on && i_hr_last);
      end
      if (i_st_r == I_FCS) begin
        if (i_adv) begin
          i_fc_r <= i_fc_r + 2'h1;
          if (i_fc_r == 2'h3) begin
            i_st_r  <= I_DATA;
            i_crc_r <= `FCS_INIT;
          end
        end
      end else if (i_take && tag_on) begin
        if (sr_full) begin
          i_crc_r <= i_crc_nxt;
        end
        sr_r     <= {sr_r[31:0], i_hr_data};
        sr_cnt_r <= sr_full ? sr_cnt_r : sr_cnt_r + 3'h1;
        if (i_hr_last) begin
          sr_cnt_r <= 3'h0;
          if (sr_full) begin
            // tag is fifth byte from the end
            itag_r      <= sr_r[31:24];
            last_tag_r  <= sr_r[31:24];
            strip_cnt_r <= strip_cnt_r + 16'h0001;
            i_st_r      <= I_FCS;
          end else begin
            i_crc_r <= `FCS_INIT;
          end
        end
      end
    end
  end

  // decoded host tag, valid with the new fcs bytes
  assign o_hs_lookup = itag_r[`ITAG_LOOKUP_BIT];
  assign o_hs_bypass = ~itag_r[`ITAG_LOOKUP_BIT] & itag_r[`ITAG_BYPASS_BIT];
  assign o_hs_prio   = itag_r[`ITAG_LOOKUP_BIT] ? 2'h0 :
                       itag_r[`ITAG_PRIO_MSB:`ITAG_PRIO_LSB];
  assign o_hs_ports  = itag_r[`ITAG_LOOKUP_BIT] ? 3'h0 : itag_r[`ITAG_PORTS_MSB:0];
  assign o_hs_valid  = hs_valid_r;
  assign o_hs_data   = hs_data_r;
  assign o_hs_last   = hs_last_r;

endmodule

// File: core/tail_tag_defines.vh
// register map, fields, resets and tag layout
`ifndef TAIL_TAG_DEFINES_VH
`define TAIL_TAG_DEFINES_VH

// ====================
// register byte offsets
`define REG_CTRL          8'h00
`define REG_STATE_P1      8'h04
`define REG_STATE_P2      8'h08
`define REG_STATE_P3      8'h0c
`define REG_FLUSH         8'h10
`define REG_STATUS        8'h14
`define REG_LAST_TAG      8'h18

// ====================
// control register fields
`define CTRL_TAG_EN_LSB   0
`define CTRL_TAG_EN_MSB   2
`define CTRL_PTP_EN_BIT   8
`define CTRL_RESET        32'h0000_0000

// per-port state register: tree t occupies bits [3t+2:3t]
`define ST_TX_EN_BIT      0
`define ST_RX_EN_BIT      1
`define ST_LRN_DIS_BIT    2
`define ST_FIELD_W        3
`define ST_TREES          8
`define ST_REG_W          24
`define ST_RESET          24'h6db6db

// flush register fields
`define FLUSH_PORT_LSB    0
`define FLUSH_PORT_MSB    2
`define FLUSH_TREE_LSB    4
`define FLUSH_TREE_MSB    6

// ====================
// outgoing tag layout
`define OTAG_PTP_BIT      7
`define OTAG_PORT_W       2

// incoming tag layout
`define ITAG_LOOKUP_BIT   6
`define ITAG_BYPASS_BIT   5
`define ITAG_PRIO_MSB     4
`define ITAG_PRIO_LSB     3
`define ITAG_PORTS_MSB    2

// frame check sequence
`define FCS_BYTES         4
`define FCS_INIT          32'hffff_ffff
`define FCS_POLY          32'hedb8_8320
`define STRIP_DEPTH       3'h5

`endif

// File: core/tree_gate.v
// spanning tree forwarding gate for one lookup result
`timescale 1ns/10ps
`include "tail_tag_defines.vh"

module tree_gate (
  input  wire [71:0] i_states,
  input  wire [2:0]  i_tree,
  input  wire [1:0]  i_src,
  input  wire [2:0]  i_dst_mask,
  input  wire [1:0]  i_host,
  input  wire        i_tag_on,
  input  wire        i_static_ovr,
  input  wire        i_bypass,
  output wire [2:0]  o_dst_mask,
  output wire        o_learn
);

  wire [2:0] fld [0:2];
  wire [2:0] src_f;
  wire       src_host;
  wire       src_fwd;
  wire       src_lrn_st;

  // ====================
  // per-port field of the selected tree, one of eight
  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_port
      wire p_host;
      assign fld[p] = i_states[p*`ST_REG_W + i_tree*`ST_FIELD_W +: `ST_FIELD_W];
      assign p_host = i_tag_on & (i_host == p);
      // host takes learning/override traffic, others need forwarding; from the host, others need tx enable, learning or bypass
      assign o_dst_mask[p] = i_dst_mask[p] & (i_src != p) &
        (p_host   ? (src_fwd | src_lrn_st | i_static_ovr) :
         src_host ? (fld[p][`ST_TX_EN_BIT] | ~fld[p][`ST_LRN_DIS_BIT] | i_bypass) :
                    (src_fwd & fld[p][`ST_TX_EN_BIT]));
    end
  endgenerate

  // ====================
  // source port classification
  assign src_f      = (i_src == 2'h3) ? 3'h4 : fld[i_src];
  assign src_host   = i_tag_on & (i_src == i_host);
  assign src_fwd    = src_host | src_f[`ST_RX_EN_BIT];
  assign src_lrn_st = ~src_f[`ST_LRN_DIS_BIT] & ~src_f[`ST_RX_EN_BIT];
  assign o_learn    = ~src_f[`ST_LRN_DIS_BIT];

endmodule

// File: verification/host_model.sv
// host processor model on the tagged host port
`timescale 1ns/10ps

module host_model (
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire       i_slow,
  input  wire       i_rx_valid,
  input  wire [7:0] i_rx_data,
  input  wire       i_rx_last,
  output reg        o_rx_ready = 1'b1,
  output reg        o_tx_valid = 1'b0,
  output reg  [7:0] o_tx_data = 8'h00,
  output reg        o_tx_last = 1'b0,
  input  wire       i_tx_ready
);
  logic [7:0] rx_q[$];
  logic       busy = 1'b0;

  // take bytes, slow stalls every other cycle
  always @(posedge i_clk) begin
    if (i_rx_valid && o_rx_ready) rx_q.push_back(i_rx_data);
    o_rx_ready <= i_rst || !i_slow || !o_rx_ready;
  end

  // released data line keeps changing
  always @(posedge i_clk) begin
    if (!busy) o_tx_data <= ~o_tx_data;
  end

  // payload, one tag byte, then four old check bytes
  task send(input int len, input logic [7:0] tag);
    int i;
    int n;
    busy = 1'b1;
    @(posedge i_clk);
    for (i = 0; i < len + 5; i++) begin
      o_tx_valid <= 1'b1;
      o_tx_data <= (i < len) ? 8'h30 ^ 8'(i) : (i == len) ? tag : 8'hc0 ^ 8'(i);
      o_tx_last <= (i == len + 4);
      n = 0;
      do begin
        @(posedge i_clk);
        n++;
      end while (!i_tx_ready && n < 100);
    end
    o_tx_valid <= 1'b0;
    o_tx_last <= 1'b0;
    busy = 1'b0;
  endtask
endmodule

// File: verification/port_state_tail_tag_props.sv
// port checks for the tail tag block
`timescale 1ns/10ps
`include "tail_tag_defines.vh"

module port_state_tail_tag_props (
  input wire        i_ref_clk,
  input wire        i_sys_rst,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [7:0]  i_paddr,
  input wire [31:0] o_prdata,
  input wire        o_pslverr,
  input wire        i_fw_valid,
  input wire [1:0]  i_fw_src,
  input wire        o_fw_valid,
  input wire [2:0]  o_fw_dst_mask,
  input wire        o_flush_req,
  input wire [2:0]  o_flush_ports,
  input wire        i_eh_valid,
  input wire        i_eh_last,
  input wire        o_eh_ready,
  input wire        o_hx_valid,
  input wire [7:0]  o_hx_data,
  input wire        o_hx_last,
  input wire        i_hx_ready,
  input wire        i_hr_valid,
  input wire        i_hr_last,
  input wire        o_hr_ready,
  input wire        o_hs_valid,
  input wire [7:0]  o_hs_data,
  input wire        o_hs_last,
  input wire        i_hs_ready,
  input wire        o_hs_lookup,
  input wire        o_hs_bypass,
  input wire [1:0]  o_hs_prio,
  input wire [2:0]  o_hs_ports,
  input wire        o_tag_on
);
  // ====================
  // last four bytes to host
  reg [31:0] hx_hist_r;

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      hx_hist_r <= 32'h0;
    end else if (o_hx_valid && i_hx_ready) begin
      hx_hist_r <= {hx_hist_r[23:0], o_hx_data};
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  // ====================
  // stream steps
  sequence s_hx_stall; o_hx_valid && !i_hx_ready; endsequence
  sequence s_hs_stall; o_hs_valid && !i_hs_ready; endsequence
  sequence s_eh_end; i_eh_valid && o_eh_ready && i_eh_last; endsequence
  sequence s_hr_end; i_hr_valid && o_hr_ready && i_hr_last; endsequence
  sequence s_hx_done; o_hx_valid && i_hx_ready && o_hx_last; endsequence

  property p_fw_answer; i_fw_valid |=> o_fw_valid; endproperty
  a_fw_answer: assert property (p_fw_answer)
    else $error("no lookup answer");
  property p_fw_no_self;
    i_fw_valid && i_fw_src != 2'h3 |=> (o_fw_dst_mask & (3'h1 << $past(i_fw_src))) == 3'h0;
  endproperty
  a_fw_no_self: assert property (p_fw_no_self)
    else $error("sent to own port");
  property p_tag_off; disable iff (1'b0) i_sys_rst |=> !o_tag_on; endproperty
  a_tag_off: assert property (p_tag_off)
    else $error("tag on after reset");
  property p_hx_hold; s_hx_stall |=> o_hx_valid && $stable(o_hx_data) && $stable(o_hx_last);
  endproperty
  a_hx_hold: assert property (p_hx_hold)
    else $error("host byte moved");
  property p_hs_hold; s_hs_stall |=> o_hs_valid && $stable(o_hs_data) && $stable(o_hs_last);
  endproperty
  a_hs_hold: assert property (p_hs_hold)
    else $error("fabric byte moved");
  property p_eh_block; s_eh_end |=> !o_eh_ready [*4]; endproperty
  a_eh_block: assert property (p_eh_block)
    else $error("input taken in trailer");
  property p_hx_end; s_eh_end |-> ##[5:80] s_hx_done; endproperty
  a_hx_end: assert property (p_hx_end)
    else $error("host frame not closed");
  property p_hx_tag;
    s_hx_done and o_tag_on |-> hx_hist_r[30:26] == 5'h0 && hx_hist_r[25:24] != 2'h3;
  endproperty
  a_hx_tag: assert property (p_hx_tag)
    else $error("bad host tag");
  property p_hs_end; s_hr_end |-> ##[1:80] (o_hs_valid && o_hs_last && i_hs_ready); endproperty
  a_hs_end: assert property (p_hs_end)
    else $error("fabric frame not closed");
  property p_lookup;
    o_hs_lookup |-> !o_hs_bypass && o_hs_prio == 2'h0 && o_hs_ports == 3'h0;
  endproperty
  a_lookup: assert property (p_lookup)
    else $error("fields used under lookup");
  property p_flush;
    o_flush_req |-> $past(i_psel && i_penable && i_pwrite && i_paddr == `REG_FLUSH)
      && o_flush_ports != 3'h0;
  endproperty
  a_flush: assert property (p_flush)
    else $error("stray flush");
  property p_unmapped;
    i_psel && i_penable && i_paddr > `REG_LAST_TAG |-> o_pslverr && o_prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped not refused");
endmodule

bind port_state_tail_tag port_state_tail_tag_props i_props (.*);

// File: verification/port_state_tail_tag_tb.sv
// bench for the tail tag block
`timescale 1ns/10ps
`include "tail_tag_defines.vh"

module port_state_tail_tag_tb;
  logic        i_ref_clk = '0, i_sys_rst = '1, i_psel = '0, i_penable = '0, i_pwrite = '0;
  logic [7:0]  i_paddr = '0, i_eh_data = '0;
  logic [31:0] i_pwdata = '0;
  logic        i_fw_valid = '0, i_fw_static_ovr = '0, i_fw_bypass = '0;
  logic [2:0]  i_fw_tree = '0, i_fw_dst_mask = '0;
  logic [1:0]  i_fw_src = '0, i_eh_src_port = '0;
  logic        i_eh_valid = '0, i_eh_last = '0, i_eh_ptp = '0, i_hs_ready = '1;
  logic        host_slow = '0, hs_slow = '0, err_v;
  logic [31:0] rd_v;
  wire  [31:0] o_prdata;
  wire         o_pready, o_pslverr, o_fw_valid, o_fw_learn, o_flush_req;
  wire  [2:0]  o_fw_dst_mask, o_flush_ports, o_flush_tree, o_hs_ports;
  wire         o_eh_ready, o_hx_valid, o_hx_last, i_hx_ready, i_hr_valid, i_hr_last;
  wire  [7:0]  o_hx_data, i_hr_data, o_hs_data;
  wire         o_hr_ready, o_hs_valid, o_hs_last, o_hs_lookup, o_hs_bypass, o_tag_on;
  wire  [1:0]  o_hs_prio, o_host_port;
  logic [7:0]  exp_q[$], got_q[$], hs_q[$];
  int          fail_count = 0;
  int          tests_run = 0;

  port_state_tail_tag i_dut (.*);

  host_model i_host (.i_clk(i_ref_clk), .i_rst(i_sys_rst), .i_slow(host_slow),
    .i_rx_valid(o_hx_valid), .i_rx_data(o_hx_data), .i_rx_last(o_hx_last),
    .o_rx_ready(i_hx_ready), .o_tx_valid(i_hr_valid), .o_tx_data(i_hr_data),
    .o_tx_last(i_hr_last), .i_tx_ready(o_hr_ready));

  always #2 i_ref_clk = ~i_ref_clk;

  // fabric sink, slow stalls
  always @(posedge i_ref_clk) begin
    if (o_hs_valid && i_hs_ready) hs_q.push_back(o_hs_data);
    i_hs_ready <= !hs_slow || !i_hs_ready;
  end

  // ====================
  // report and compare
  task final_report;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task timeout;
    fail_count++;
    $display("FAIL %0t wait limit reached", $time);
    final_report();
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] crc_add(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h0, d};
    for (int k = 0; k < 8; k++) r = r[0] ? ((r >> 1) ^ `FCS_POLY) : (r >> 1);
    return r;
  endfunction

  // append fcs of exp_q, low byte first
  task add_fcs;
    logic [31:0] c;
    c = `FCS_INIT;
    foreach (exp_q[i]) c = crc_add(c, exp_q[i]);
    c = ~c;
    for (int k = 0; k < 4; k++) exp_q.push_back(c[8*k +: 8]);
  endtask

  task frame_chk(input logic hs);
    int n;
    for (n = 0; n < 300; n++) begin
      if ((hs ? hs_q.size() : i_host.rx_q.size()) >= exp_q.size()) break;
      @(posedge i_ref_clk);
    end
    if (n == 300) timeout();
    got_q = hs ? hs_q : i_host.rx_q;
    chk(32'(got_q.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) chk({24'h0, got_q[i]}, {24'h0, exp_q[i]});
    hs_q.delete();
    i_host.rx_q.delete();
    exp_q.delete();
  endtask

  // ====================
  // bus and stream drivers
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_ref_clk);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_ref_clk);
      if (o_pready === 1'h1) break;
    end
    rd_v = o_prdata;
    err_v = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    if (n == 50) timeout();
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd_v, exp);
  endtask

  task look(input logic [2:0] t, input logic [1:0] s, input logic [2:0] d,
            input logic ov, input logic by, input logic [2:0] em, input logic el);
    @(posedge i_ref_clk);
    i_fw_valid <= 1'h1;
    i_fw_tree <= t;
    i_fw_src <= s;
    i_fw_dst_mask <= d;
    i_fw_static_ovr <= ov;
    i_fw_bypass <= by;
    @(posedge i_ref_clk);
    i_fw_valid <= 1'h0;
    #1;
    chk({28'h0, o_fw_valid, o_fw_dst_mask, o_fw_learn}, {28'h0, 1'h1, em, el});
  endtask

  task to_host(input int len, input logic [1:0] src, input logic ptp,
               input logic [7:0] tag, input logic on);
    int i;
    int n;
    @(posedge i_ref_clk);
    for (i = 0; i < len; i++) begin
      i_eh_valid <= 1'h1;
      i_eh_data <= 8'ha0 ^ 8'(i);
      i_eh_last <= (i == len - 1);
      i_eh_src_port <= src;
      i_eh_ptp <= ptp;
      exp_q.push_back(8'ha0 ^ 8'(i));
      n = 0;
      do begin
        @(posedge i_ref_clk);
        n++;
      end while (!o_eh_ready && n < 100);
      if (n == 100) timeout();
    end
    i_eh_valid <= 1'h0;
    i_eh_last <= 1'h0;
    if (on) exp_q.push_back(tag);
    add_fcs();
    frame_chk(1'h0);
  endtask

  task host_tx(input int len, input logic [7:0] tag, input logic on);
    for (int i = 0; i < len; i++) exp_q.push_back(8'h30 ^ 8'(i));
    if (on) add_fcs();
    else begin
      exp_q.push_back(tag);
      for (int j = len + 1; j < len + 5; j++) exp_q.push_back(8'hc0 ^ 8'(j));
    end
    i_host.send(len, tag);
    frame_chk(1'h1);
  endtask

  // ====================
  // main sequence
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_sys_rst <= 1'h0;
    rd(`REG_CTRL, `CTRL_RESET);
    rd(`REG_STATE_P3, {8'h0, `ST_RESET});
    apb(1'h0, 8'h1c, 32'h0);
    chk({31'h0, err_v}, 32'h1);
    apb(1'h1, `REG_CTRL, 32'h104);
    #1 chk({29'h0, o_tag_on, o_host_port}, 32'h6);
    apb(1'h1, `REG_STATE_P1, 32'h006d_b703);
    rd(`REG_STATE_P1, 32'h006d_b703);
    look(3'h0, 2'h0, 3'h2, 1'h0, 1'h0, 3'h2, 1'h1);
    look(3'h0, 2'h1, 3'h7, 1'h0, 1'h0, 3'h5, 1'h1);
    look(3'h1, 2'h0, 3'h2, 1'h0, 1'h0, 3'h0, 1'h1);
    look(3'h1, 2'h1, 3'h1, 1'h0, 1'h0, 3'h0, 1'h1);
    look(3'h1, 2'h0, 3'h4, 1'h0, 1'h0, 3'h4, 1'h1);
    look(3'h1, 2'h2, 3'h1, 1'h0, 1'h0, 3'h1, 1'h1);
    look(3'h2, 2'h0, 3'h4, 1'h0, 1'h0, 3'h0, 1'h0);
    look(3'h2, 2'h0, 3'h4, 1'h1, 1'h0, 3'h4, 1'h0);
    look(3'h2, 2'h2, 3'h1, 1'h0, 1'h0, 3'h0, 1'h1);
    look(3'h2, 2'h2, 3'h1, 1'h0, 1'h1, 3'h1, 1'h1);
    apb(1'h1, `REG_FLUSH, 32'h23);
    #1 chk({24'h0, o_flush_req, o_flush_tree, 1'h0, o_flush_ports}, 32'ha1);
    apb(1'h1, `REG_FLUSH, 32'h3);
    #1 chk({31'h0, o_flush_req}, 32'h0);
    to_host(6, 2'h1, 1'h1, 8'h81, 1'h1);
    host_slow <= 1'h1;
    to_host(5, 2'h0, 1'h0, 8'h00, 1'h1);
    to_host(4, 2'h2, 1'h1, 8'h82, 1'h1);
    host_slow <= 1'h0;
    host_tx(7, 8'h0b, 1'h1);
    chk({25'h0, o_hs_lookup, o_hs_bypass, o_hs_prio, o_hs_ports}, 32'h0b);
    hs_slow <= 1'h1;
    host_tx(7, 8'h25, 1'h1);
    chk({25'h0, o_hs_lookup, o_hs_bypass, o_hs_prio, o_hs_ports}, 32'h25);
    host_tx(7, 8'h7f, 1'h1);
    chk({25'h0, o_hs_lookup, o_hs_bypass, o_hs_prio, o_hs_ports}, 32'h40);
    hs_slow <= 1'h0;
    rd(`REG_STATUS, 32'h0003_0003);
    apb(1'h1, `REG_CTRL, 32'h0);
    to_host(5, 2'h1, 1'h1, 8'h00, 1'h0);
    host_tx(7, 8'h0b, 1'h0);
    rd(`REG_STATUS, 32'h0003_0003);
    final_report();
  end
endmodule
